// >>> sefp_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts for the
 * socket event-injection and supply-control register bank.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef SEFP_REGS_SVH
`define SEFP_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// Byte offsets on the register bus
`define SEFP_OFF_INJECT        12'h00c
`define SEFP_OFF_SUPPLY        12'h010
`define SEFP_OFF_STATE         12'h020
`define SEFP_OFF_PRESENT       12'h024
`define SEFP_OFF_EVENT         12'h028

////////////////////////////////////////////////////////////////////////////////
// Injection register bit positions
`define SEFP_INJ_REINTERROGATE 14
`define SEFP_INJ_YV            13
`define SEFP_INJ_XV            12
`define SEFP_INJ_THREE         11
`define SEFP_INJ_FIVE          10
`define SEFP_INJ_BADREQ        9
`define SEFP_INJ_DATALOSS      8
`define SEFP_INJ_UNRECOG       7
`define SEFP_INJ_WIDE          5
`define SEFP_INJ_NARROW        4
`define SEFP_INJ_POWER         3
`define SEFP_INJ_DET2          2
`define SEFP_INJ_DET1          1
`define SEFP_INJ_STATUS        0

////////////////////////////////////////////////////////////////////////////////
// Supply control fields and codes
`define SEFP_SUP_STOPCLK       7
`define SEFP_SUP_CORE_LSB      4
`define SEFP_SUP_PROG_LSB      0
`define SEFP_SUP_MASK          32'h0000_00f7
`define SEFP_SUP_RESET         32'h0000_0000
`define SEFP_CODE_OFF          3'h0
`define SEFP_CODE_12V          3'h1
`define SEFP_CODE_5V           3'h2
`define SEFP_CODE_3V3          3'h3
`define SEFP_CODE_XV           3'h4
`define SEFP_CODE_YV           3'h5

////////////////////////////////////////////////////////////////////////////////
// Interrogation timing: cycles the card identification takes
`define SEFP_INTERROGATE_CYCLES 8'h10
// Cycles after reset before pin edges count; a filling synchroniser raises no event
`define SEFP_SETTLE_CYCLES      3'h7

`endif

// >>> sefp_pkg.sv
/*
 * Types shared by the socket register bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sefp_pkg;

	// Capability and card-type flags held in the present-state register
	typedef struct packed {
		logic yvCapable;
		logic xvCapable;
		logic threeVoltCapable;
		logic fiveVoltCapable;
		logic badSupplyRequest;
		logic dataLoss;
		logic unrecognisedCard;
		logic wideBusCard;
		logic narrowCard;
	} sefp_card_flags_t;

	// Sticky socket events
	typedef struct packed {
		logic powerChange;
		logic detectTwo;
		logic detectOne;
		logic statusChange;
	} sefp_events_t;

	// Supply request towards the power switch
	typedef struct packed {
		logic [2:0] core;
		logic [2:0] prog;
	} sefp_supply_t;

	// Interrogation sequencer states
	typedef enum logic [1:0] {
		SEFP_IDLE  = 2'b01,
		SEFP_PROBE = 2'b10
	} sefp_probe_state_t;

endpackage

// >>> sefp_sync.sv
/*
 * Three-stage synchroniser with agreement filter for asynchronous pins.
 * Assumes clk is the bus clock; output changes only when stages two and
 * three agree.
 */
`timescale 1ns/1ps

module sefp_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             clk,   // Bus clock
	input  wire logic             srst,  // Synchronous reset
	input  wire logic [WIDTH-1:0] din,   // Asynchronous pins
	output logic      [WIDTH-1:0] dout   // Filtered level
);

	logic [WIDTH-1:0] s1Q;
	logic [WIDTH-1:0] s2Q;
	logic [WIDTH-1:0] s3Q;

	initial begin
		if (WIDTH < 1) $error("sefp_sync: WIDTH must be positive");
	end

	////////////////////////////////////////////////////////////////////////////
	// Stage one feeds only stage two
	always_ff @(posedge clk) begin
		if (srst) begin
			s1Q <= '0;
			s2Q <= '0;
			s3Q <= '0;
		end else begin
			s1Q <= din;
			s2Q <= s1Q;
			s3Q <= s2Q;
		end
	end

	// Agreement filter rejects a single-cycle metastable value
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : gFilt
			always_ff @(posedge clk) begin
				if (srst) begin
					dout[g] <= 1'b0;
				end else if (s2Q[g] == s3Q[g]) begin
					dout[g] <= s3Q[g];
				end
			end
		end
	endgenerate

endmodule

// >>> sefp_supply_guard.sv
/*
 * Limits the requested socket supplies to those an inserted wide-bus card accepts.
 * Assumes flags come from the present-state logic on the same clock.
 */
`timescale 1ns/1ps
`include "sefp_regs.svh"

module sefp_supply_guard (
	input  wire logic                      clk,       // Bus clock
	input  wire logic                      srst,      // Synchronous reset
	input  wire logic                      enable,    // Power control enabled
	input  wire sefp_pkg::sefp_supply_t    request,   // Software request
	input  wire sefp_pkg::sefp_card_flags_t flags,    // Card capability
	output sefp_pkg::sefp_supply_t         applied,   // Registered supply
	output logic                           badReq     // Bad request, high while it is held
);

	// Checks one core code against the card capabilities
	function automatic logic core_ok(input logic [2:0] c, input sefp_pkg::sefp_card_flags_t f);
		case (c)
			`SEFP_CODE_OFF: core_ok = 1'b1;
			`SEFP_CODE_5V:  core_ok = f.fiveVoltCapable;
			`SEFP_CODE_3V3: core_ok = f.threeVoltCapable;
			`SEFP_CODE_XV:  core_ok = f.xvCapable;
			`SEFP_CODE_YV:  core_ok = f.yvCapable;
			default:        core_ok = 1'b0;
		endcase
	endfunction

	wire logic coreOk = core_ok(request.core, flags);
	// Wide-bus cards never take 12 V or 5 V programming supply
	wire logic progOk = (request.prog <= `SEFP_CODE_YV) &&
		!(flags.wideBusCard && (request.prog == `SEFP_CODE_12V || request.prog == `SEFP_CODE_5V));
	wire logic reqOk  = !flags.wideBusCard || (coreOk && progOk);
	wire logic legal  = reqOk && request.core != 3'h1 && request.core <= `SEFP_CODE_YV
		&& request.prog <= `SEFP_CODE_YV;

	////////////////////////////////////////////////////////////////////////////
	// Unacceptable or disabled requests leave the socket unpowered
	always_ff @(posedge clk) begin
		if (srst) begin
			applied <= '0;
			badReq  <= 1'b0;
		end else begin
			applied <= (enable && legal) ? request : '0; // RULE_16 RULE_05
			badReq  <= enable && !legal && (request != '0);
		end
	end

endmodule

// >>> sefp_bank.sv
/*
 * Socket event-injection and supply-control register bank with APB slave.
 * Assumes a 32-bit APB master on clk, card pins asynchronous to clk, and a
 * power switch that accepts the registered supply outputs.
 */
// Functional notes
// RULE_01: Injection register bits 31 to 15 always read as zero.
// RULE_02: Writing bit 14 re-interrogates the card, refreshes flags, re-enables power.
// RULE_03: Software sets bit 14 whenever its forced change needs interrogation.
// RULE_04: Bits 13 to 10 load the YV, XV, 3 V, 5 V capability flags.
// RULE_05: Setting any forced voltage bit disables power control until re-interrogation.
// RULE_06: Bit 9 writes the bad supply request flag.
// RULE_07: Bit 8 writes the data loss flag.
// RULE_08: Bit 7 writes the unrecognised card flag.
// RULE_09: Bit 6 is reserved, reads zero, writes ignored.
// RULE_10: Bit 5 writes the wide bus card flag.
// RULE_11: Bit 4 writes the narrow card flag.
// RULE_12: Bit 3 sets the power change event; powered flag untouched.
// RULE_13: Bit 2 sets detect two event; live level untouched.
// RULE_14: Bit 1 sets detect one event; live level untouched.
// RULE_15: Bit 0 sets status change event; live level untouched.
// RULE_16: With a wide bus card only acceptable supplies are applied.
// RULE_17: Supply control writable bits 7, 6-4, 2-0 reset zero; others read zero.
// RULE_18: Supply fields cleared by bus reset only when wake events disabled.
// RULE_19: Core field: 0 off, 2 5 V, 3 3.3 V, 4 X.X, 5 Y.Y.
// RULE_20: Programming field: 0 off, 1 12 V, 2 5 V, 3 3.3 V, 4 X.X, 5 Y.Y.
// RULE_21: Injection register is not stored and reads as all zero.
`timescale 1ns/1ps
`include "sefp_regs.svh"

module sefp_bank #(
	parameter int ADDR_WIDTH = 12
) (
	input  wire logic                   clk,            // Bus clock, 40 MHz
	input  wire logic                   srst,           // Global synchronous reset
	input  wire logic                   busResetPin,    // Card bus reset, async
	input  wire logic                   wakeEnable,     // Wake events enabled
	input  wire logic                   psel,           // APB select
	input  wire logic                   penable,        // APB enable
	input  wire logic                   pwrite,         // APB direction
	input  wire logic [ADDR_WIDTH-1:0]  paddr,          // APB byte address
	input  wire logic [31:0]            pwdata,         // APB write data
	output logic      [31:0]            prdata,         // APB read data
	output logic                        pready,         // APB ready
	output logic                        pslverr,        // APB error
	input  wire logic                   cardDetectOnePin, // Detect one, async
	input  wire logic                   cardDetectTwoPin, // Detect two, async
	input  wire logic                   cardStatusChangePin, // Status change, async
	input  wire sefp_pkg::sefp_card_flags_t probeResult, // Interrogation result
	output logic                        probeActive,    // Interrogation running
	output sefp_pkg::sefp_supply_t      supplyApplied,  // Supply to power switch
	output logic                        stopClockMode   // Clock stop policy
);

	initial begin
		if (ADDR_WIDTH < 6) $error("sefp_bank: ADDR_WIDTH too small");
	end

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	sefp_pkg::sefp_card_flags_t flagsQ;
	sefp_pkg::sefp_events_t     eventsQ;
	sefp_pkg::sefp_supply_t     supplyQ;
	sefp_pkg::sefp_probe_state_t stateQ;
	logic       stopClkQ;
	logic       powerEnableQ;
	logic       poweredQ;
	logic [7:0] probeCntQ;
	logic [2:0] pinLevel;
	logic [2:0] pinLevelQ;
	logic [1:0] busRstSyncQ;
	logic       busRstLevel;
	sefp_pkg::sefp_supply_t appliedW;
	logic       badReqPulse;
	logic [2:0] settleCntQ;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: detect two, detect one, status change; bus reset
	sefp_sync #(.WIDTH(3)) uPinSync (
		.clk  (clk),
		.srst (srst),
		.din  ({cardDetectTwoPin, cardDetectOnePin, cardStatusChangePin}),
		.dout (pinLevel)
	);

	sefp_sync #(.WIDTH(1)) uRstSync (
		.clk  (clk),
		.srst (srst),
		.din  (busResetPin),
		.dout (busRstLevel)
	);

	////////////////////////////////////////////////////////////////////////////
	// APB decode; single-cycle access phase
	wire logic        access   = psel && penable;
	wire logic        wrStrobe = access && pwrite;
	wire logic [11:0] addr12   = {{(12 - 6){1'b0}}, paddr[5:0]};
	wire logic        upperZero = (paddr >> 6) == '0;
	wire logic        hitInject = upperZero && addr12 == `SEFP_OFF_INJECT;
	wire logic        hitSupply = upperZero && addr12 == `SEFP_OFF_SUPPLY;
	wire logic        hitState  = upperZero && addr12 == `SEFP_OFF_STATE;
	wire logic        hitPresent = upperZero && addr12 == `SEFP_OFF_PRESENT;
	wire logic        hitEvent  = upperZero && addr12 == `SEFP_OFF_EVENT;
	wire logic        hitAny    = hitInject | hitSupply | hitState | hitPresent | hitEvent;
	wire logic        injWr     = wrStrobe && hitInject;
	wire logic        supWr     = wrStrobe && hitSupply;
	wire logic        evtWr     = wrStrobe && hitEvent;

	// Injection bits; bit 6 and bits 31..15 have no decode at all
	wire logic reinterrogate = injWr && pwdata[`SEFP_INJ_REINTERROGATE];   // RULE_02
	wire logic forcedVoltage = injWr && (pwdata[`SEFP_INJ_YV] | pwdata[`SEFP_INJ_XV] |
		pwdata[`SEFP_INJ_THREE] | pwdata[`SEFP_INJ_FIVE]);                  // RULE_05
	wire logic probeDone = (stateQ == sefp_pkg::SEFP_PROBE) && (probeCntQ == 8'h00);

	////////////////////////////////////////////////////////////////////////////
	// Interrogation sequencer
	always_ff @(posedge clk) begin
		if (srst) begin
			stateQ    <= sefp_pkg::SEFP_IDLE;
			probeCntQ <= 8'h00;
		end else begin
			case (stateQ)
				sefp_pkg::SEFP_IDLE: begin
					if (reinterrogate) begin                          // RULE_02
						stateQ    <= sefp_pkg::SEFP_PROBE;
						probeCntQ <= `SEFP_INTERROGATE_CYCLES - 8'h01;
					end
				end
				sefp_pkg::SEFP_PROBE: begin
					if (probeCntQ == 8'h00) begin
						stateQ <= sefp_pkg::SEFP_IDLE;
					end else begin
						probeCntQ <= probeCntQ - 8'h01;
					end
				end
				default: begin
					stateQ <= sefp_pkg::SEFP_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power control enable: forced voltages disable, interrogation restores
	always_ff @(posedge clk) begin
		if (srst) begin
			powerEnableQ <= 1'b1;
		end else if (probeDone) begin
			powerEnableQ <= 1'b1;                                    // RULE_02
		end else if (forcedVoltage) begin
			powerEnableQ <= 1'b0;                                    // RULE_05
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Present-state flags: written from injection, refreshed by interrogation
	always_ff @(posedge clk) begin
		if (srst) begin
			flagsQ <= '0;
		end else if (probeDone) begin
			flagsQ <= probeResult;                                   // RULE_02
		end else if (injWr) begin
			flagsQ.yvCapable        <= pwdata[`SEFP_INJ_YV];         // RULE_04
			flagsQ.xvCapable        <= pwdata[`SEFP_INJ_XV];         // RULE_04
			flagsQ.threeVoltCapable <= pwdata[`SEFP_INJ_THREE];      // RULE_04
			flagsQ.fiveVoltCapable  <= pwdata[`SEFP_INJ_FIVE];       // RULE_04
			flagsQ.badSupplyRequest <= pwdata[`SEFP_INJ_BADREQ] | badReqPulse; // RULE_06
			flagsQ.dataLoss         <= pwdata[`SEFP_INJ_DATALOSS];   // RULE_07
			flagsQ.unrecognisedCard <= pwdata[`SEFP_INJ_UNRECOG];    // RULE_08
			flagsQ.wideBusCard      <= pwdata[`SEFP_INJ_WIDE];       // RULE_10
			flagsQ.narrowCard       <= pwdata[`SEFP_INJ_NARROW];     // RULE_11
		end else if (badReqPulse) begin
			flagsQ.badSupplyRequest <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Live pin levels frozen during interrogation, since probing drives them
	always_ff @(posedge clk) begin
		if (srst) begin
			pinLevelQ <= 3'h0;
		end else if (stateQ == sefp_pkg::SEFP_IDLE) begin
			pinLevelQ <= pinLevel;
		end
	end

	// Settle count after reset; pins idle high would otherwise look like an edge from zero
	always_ff @(posedge clk) begin
		if (srst) begin
			settleCntQ <= 3'h0;
		end else if (settleCntQ != `SEFP_SETTLE_CYCLES) begin
			settleCntQ <= settleCntQ + 3'h1;
		end
	end

	wire logic pinsSettled = settleCntQ == `SEFP_SETTLE_CYCLES;

	// Level edges feed the sticky events
	wire logic [2:0] pinEdge = (pinLevelQ ^ pinLevel) & {3{stateQ == sefp_pkg::SEFP_IDLE && pinsSettled}};
	wire logic poweredNow = supplyApplied != '0;

	always_ff @(posedge clk) begin
		if (srst) begin
			poweredQ <= 1'b0;
		end else begin
			poweredQ <= poweredNow;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sticky events: write one to clear, a set in the same cycle wins
	wire logic setPower  = (injWr && pwdata[`SEFP_INJ_POWER]) || (poweredQ != poweredNow); // RULE_12
	wire logic setDetTwo = (injWr && pwdata[`SEFP_INJ_DET2]) || pinEdge[2];               // RULE_13
	wire logic setDetOne = (injWr && pwdata[`SEFP_INJ_DET1]) || pinEdge[1];               // RULE_14
	wire logic setStatus = (injWr && pwdata[`SEFP_INJ_STATUS]) || pinEdge[0];             // RULE_15

	always_ff @(posedge clk) begin
		if (srst) begin
			eventsQ <= '0;
		end else begin
			eventsQ.powerChange  <= setPower  | (eventsQ.powerChange  & ~(evtWr & pwdata[3]));
			eventsQ.detectTwo    <= setDetTwo | (eventsQ.detectTwo    & ~(evtWr & pwdata[2]));
			eventsQ.detectOne    <= setDetOne | (eventsQ.detectOne    & ~(evtWr & pwdata[1]));
			eventsQ.statusChange <= setStatus | (eventsQ.statusChange & ~(evtWr & pwdata[0]));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Supply control register; fields survive bus reset while wake is enabled
	wire logic clearSupply = busRstLevel && !wakeEnable;              // RULE_18

	always_ff @(posedge clk) begin
		if (srst) begin
			supplyQ  <= '0;                                          // RULE_17
			stopClkQ <= 1'b0;                                        // RULE_17
		end else if (supWr) begin
			supplyQ.core <= pwdata[`SEFP_SUP_CORE_LSB +: 3];         // RULE_19
			supplyQ.prog <= pwdata[`SEFP_SUP_PROG_LSB +: 3];         // RULE_20
			stopClkQ     <= pwdata[`SEFP_SUP_STOPCLK];
		end else if (clearSupply) begin
			supplyQ <= '0;                                           // RULE_18
		end
	end

	sefp_supply_guard uGuard (
		.clk     (clk),
		.srst    (srst),
		.enable  (powerEnableQ),
		.request (supplyQ),
		.flags   (flagsQ),
		.applied (appliedW),
		.badReq  (badReqPulse)
	);

	////////////////////////////////////////////////////////////////////////////
	// Read mux; injection register reads as zero in full
	wire logic [31:0] supplyRd = {24'h000000, stopClkQ, supplyQ.core, 1'b0, supplyQ.prog} &
		`SEFP_SUP_MASK;                                              // RULE_17
	wire logic [31:0] stateRd = {29'h0, stateQ == sefp_pkg::SEFP_PROBE, powerEnableQ, poweredQ};
	wire logic [31:0] presentRd = {18'h0, flagsQ.yvCapable, flagsQ.xvCapable,
		flagsQ.threeVoltCapable, flagsQ.fiveVoltCapable, flagsQ.badSupplyRequest,
		flagsQ.dataLoss, flagsQ.unrecognisedCard, 1'b0, flagsQ.wideBusCard,
		flagsQ.narrowCard, poweredQ, pinLevelQ};
	wire logic [31:0] eventRd = {28'h0, eventsQ};
	wire logic [31:0] rdMux = hitSupply  ? supplyRd :
		hitState   ? stateRd :
		hitPresent ? presentRd :
		hitEvent   ? eventRd : 32'h0000_0000;                        // RULE_01 RULE_09 RULE_21

	////////////////////////////////////////////////////////////////////////////
	// APB answer registered: pready rises the cycle after setup, with penable
	always_ff @(posedge clk) begin
		if (srst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			prdata  <= (psel && !penable && !pwrite) ? rdMux : 32'h0000_0000;
			pslverr <= psel && !penable && !hitAny;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registered outputs
	always_ff @(posedge clk) begin
		if (srst) begin
			probeActive   <= 1'b0;
			supplyApplied <= '0;
			stopClockMode <= 1'b0;
		end else begin
			probeActive   <= stateQ == sefp_pkg::SEFP_PROBE;
			supplyApplied <= appliedW;                               // RULE_16
			stopClockMode <= stopClkQ;
		end
	end

endmodule

// >>> sefp_bank_assertions.sv
/*
 * Port-level checks on the socket event-injection and supply-control bank.
 * Assumes the bank's APB contract: one access cycle, pready a one-cycle pulse.
 */
`timescale 1ns/1ps
`include "sefp_regs.svh"

module sefp_bank_assertions #(
	parameter int ADDR_WIDTH = 12
) (
	input wire logic                  clk,           // Bus clock
	input wire logic                  srst,          // Global reset
	input wire logic                  psel,          // APB select
	input wire logic                  penable,       // APB enable
	input wire logic                  pwrite,        // APB direction
	input wire logic [ADDR_WIDTH-1:0] paddr,         // APB address
	input wire logic [31:0]           pwdata,        // APB write data
	input wire logic [31:0]           prdata,        // APB read data
	input wire logic                  pready,        // APB ready
	input wire logic                  pslverr,       // APB error
	input wire logic                  probeActive,   // Interrogation running
	input wire sefp_pkg::sefp_supply_t supplyApplied, // Applied supply
	input wire logic                  stopClockMode  // Clock stop policy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	////////////////////////////////////////////////////////////////////////////////
	// Decoded completed accesses, named so the properties stay readable
	wire logic rdDone = pready && psel && penable && !pwrite;
	wire logic wrDone = pready && psel && penable && pwrite;
	wire logic supWr  = wrDone && paddr == `SEFP_OFF_SUPPLY;
	wire logic injWr  = wrDone && paddr == `SEFP_OFF_INJECT;

	////////////////////////////////////////////////////////////////////////////////
	// Bus handshake and register contents
	ready_after_setup_a: assert property (psel && !penable |=> pready) else $error("no answer after setup");
	ready_one_cycle_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	ready_in_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
	err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
	rdata_idle_a: assert property (!rdDone |-> prdata == 32'h0) else $error("read data outside read answer");
	inject_reads_zero_a: assert property (
		rdDone && paddr == `SEFP_OFF_INJECT |-> prdata == 32'h0) else $error("injection register read nonzero");
	supply_reserved_a: assert property (
		rdDone && paddr == `SEFP_OFF_SUPPLY |-> (prdata & ~`SEFP_SUP_MASK) == 32'h0) else $error("reserved supply bits set");
	stop_follows_a: assert property (
		supWr |-> ##2 stopClockMode == $past(pwdata[7], 2)) else $error("stop clock bit not taken");
	probe_start_a: assert property (injWr && pwdata[14] |-> ##[1:3] probeActive) else $error("no interrogation");
	probe_length_a: assert property (
		$rose(probeActive) |-> probeActive[*8] ##[1:12] !probeActive) else $error("interrogation length wrong");
	power_off_a: assert property (
		injWr && |pwdata[13:10] && !pwdata[14] |-> ##[2:4] supplyApplied == '0) else $error("power stays on");
	codes_legal_a: assert property (
		supplyApplied.core != 3'h1 && supplyApplied.core < 3'h6 && supplyApplied.prog < 3'h6)
		else $error("reserved supply code applied");
endmodule

bind sefp_bank sefp_bank_assertions #(.ADDR_WIDTH(ADDR_WIDTH)) i_sefp_bank_assertions (.clk(clk), .srst(srst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .probeActive(probeActive), .supplyApplied(supplyApplied),
	.stopClockMode(stopClockMode));

// >>> socket_event_force_and_power_control_tb.sv
/*
 * Self-checking bench for the socket register bank, acting as APB master.
 * Assumes the bank answers every access after one access cycle.
 */
`timescale 1ns/1ps
`include "sefp_regs.svh"

module socket_event_force_and_power_control_tb;
	logic                       clk, srst, busResetPin, wakeEnable;
	logic                       psel, penable, pwrite, pready, pslverr, err;
	logic [11:0]                paddr;
	logic [31:0]                pwdata, prdata, rd, seed, d;
	logic                       cd1, cd2, css, probeActive, stopClockMode;
	logic [8:0]                 pr;
	sefp_pkg::sefp_card_flags_t probeResult;
	sefp_pkg::sefp_supply_t     supplyApplied;
	int                         num_errors, n_checks;

	sefp_bank i_sefp_bank (.clk(clk), .srst(srst), .busResetPin(busResetPin), .wakeEnable(wakeEnable),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cardDetectOnePin(cd1), .cardDetectTwoPin(cd2),
		.cardStatusChangePin(css), .probeResult(probeResult), .probeActive(probeActive),
		.supplyApplied(supplyApplied), .stopClockMode(stopClockMode));

	// 40 MHz bus clock
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Stimulus and expectation helpers
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Reserved codes on either field must keep the socket unpowered
	function logic [31:0] expSup(input logic [2:0] c, input logic [2:0] p);
		if (c == 3'h1 || c > 3'h5 || p > 3'h5) return 32'h0;
		return {26'h0, c, p};
	endfunction

	function logic [31:0] expFlags(input logic [8:0] f);
		return {18'h0, f[8:2], 1'b0, f[1:0], 4'h0};
	endfunction

	task end_of_test();
		if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Request held until pready is sampled high, then released for one edge
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] v);
		int i;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clk);
		penable <= 1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (pready !== 1'b1) begin
			num_errors++;
			end_of_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask

	task wr(input logic [11:0] a, input logic [31:0] v);
		xfer(1, a, v);
	endtask

	task rdc(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
		xfer(0, a, 32'h0);
		chk(rd & mask, exp);
	endtask

	// Re-interrogation; the wait is bounded since a stuck probe would hang the run
	task probe();
		int i;
		bit seen;
		wr(`SEFP_OFF_INJECT, 32'h4000);
		seen = 0;
		for (i = 0; i < 60 && !(seen && probeActive === 1'b0); i++) begin
			seen |= probeActive === 1'b1;
			@(posedge clk);
		end
		if (i == 60) begin
			num_errors++;
			end_of_test();
		end
		repeat (4) @(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		seed = 50;
		num_errors = 0;
		n_checks = 0;
		{psel, penable, pwrite, busResetPin, wakeEnable} = '0;
		paddr = '0;
		pwdata = '0;
		probeResult = '0;
		d = rnd();
		{cd2, cd1, css} = d[2:0];
		srst = 1;
		repeat (20) @(posedge clk);
		srst <= 0;
		@(posedge clk);
		rdc(`SEFP_OFF_SUPPLY, 32'hffffffff, `SEFP_SUP_RESET);
		rdc(12'h0fc, 32'hffffffff, 32'h0);
		chk(err, 1);
		for (int k = 0; k < 6; k++) begin
			d = rnd();
			wr(`SEFP_OFF_SUPPLY, d);
			rdc(`SEFP_OFF_SUPPLY, 32'hffffffff, d & `SEFP_SUP_MASK);
		end
		rdc(`SEFP_OFF_EVENT, 32'h7, 32'h0);
		// Every code pair on both fields, card type unknown so any legal code passes
		for (int c = 0; c < 8; c++) begin
			for (int p = 0; p < 8; p++) begin
				wr(`SEFP_OFF_SUPPLY, {25'h0, 3'(c), 1'b0, 3'(p)});
				repeat (4) @(posedge clk);
				chk({26'h0, supplyApplied}, expSup(3'(c), 3'(p)));
			end
		end
		wr(`SEFP_OFF_SUPPLY, 32'h20);
		for (int k = 0; k < 4; k++) begin
			wr(`SEFP_OFF_INJECT, 32'h400 << k);
			repeat (4) @(posedge clk);
			chk({26'h0, supplyApplied}, 32'h0);
			rdc(`SEFP_OFF_STATE, 32'h2, 32'h0);
			rdc(`SEFP_OFF_PRESENT, 32'h3c00, 32'h400 << k);
			rd = rnd();
			pr = rd[8:0] & 9'h1fd;
			probeResult <= pr;
			probe();
			rdc(`SEFP_OFF_PRESENT, 32'h3fb0, expFlags(pr));
			chk({26'h0, supplyApplied}, 32'h10);
		end
		// Wide-bus card able to take only 3.3 V
		probeResult <= 9'h042;
		probe();
		wr(`SEFP_OFF_SUPPLY, 32'h20);
		repeat (4) @(posedge clk);
		chk({26'h0, supplyApplied}, 32'h0);
		wr(`SEFP_OFF_SUPPLY, 32'h31);
		repeat (4) @(posedge clk);
		chk({26'h0, supplyApplied}, 32'h0);
		wr(`SEFP_OFF_SUPPLY, 32'h33);
		repeat (4) @(posedge clk);
		chk({26'h0, supplyApplied}, 32'h1b);
		rdc(`SEFP_OFF_STATE, 32'h7, 32'h3);
		wr(`SEFP_OFF_SUPPLY, 32'h0);
		for (int k = 0; k < 6; k++) begin
			d = rnd() & 32'hffffbfff;
			wr(`SEFP_OFF_INJECT, d);
			rdc(`SEFP_OFF_PRESENT, 32'h3fb0, d & 32'h3fb0);
			rdc(`SEFP_OFF_INJECT, 32'hffffffff, 32'h0);
		end
		wr(`SEFP_OFF_EVENT, 32'hf);
		for (int k = 0; k < 4; k++) begin
			wr(`SEFP_OFF_INJECT, 32'h1 << k);
			rdc(`SEFP_OFF_EVENT, 32'hf, 32'h1 << k);
			rdc(`SEFP_OFF_PRESENT, 32'hf, {28'h0, 1'b0, cd2, cd1, css});
			wr(`SEFP_OFF_EVENT, 32'h1 << k);
		end
		// Bus reset spares the supply fields only while wake events are enabled
		for (int k = 1; k >= 0; k--) begin
			wakeEnable <= k[0];
			wr(`SEFP_OFF_SUPPLY, 32'hb3);
			busResetPin <= 1;
			repeat (8) @(posedge clk);
			busResetPin <= 0;
			repeat (6) @(posedge clk);
			rdc(`SEFP_OFF_SUPPLY, 32'hffffffff, k ? 32'hb3 : 32'h80);
			chk(stopClockMode, 1);
		end
		end_of_test();
	end
endmodule
